//--- dsc_channel.sv
// One event-paced DMA channel with double-word split and frame counting
//
// Operation
// - Paced channel waits for selected event
// - No trigger code runs elements back-to-back
// - One event consumed per element
// - Double-word element is two 16-bit moves
// - One 4-bit trigger select, resets to zero
// - Codes 1,2,5,6 select ports 0,1
// - Codes 3,4 third port, else reserved
// - Two-port: D,E,F timer0, irq3, timer1
// - Alt-stream variant: 7-C alt, D timer, E irq3
// - Subsystem: 7,8 FIFO events, rest reserved
// - Channel sequences both moves, any indexing
// - Second move flips address LSB
// - Double-word bit set enables, reset clears
// - 8-bit frame count minus one, resets zero
// - Frame count decrements per finished frame
// - Autoinit reloads frame count from global
// - Transfers equal element times frame count
// - CPU write beats controller frame update
// - Field layout, reserved bits ignore writes
// - Element counter decrements, reloads from shadow
`include "dsc_map.svh"
`timescale 1ns/10ps
`default_nettype none

module dsc_channel #(
  parameter dsc_pkg::dsc_variant_t VARIANT = dsc_pkg::DSC_VAR_TWO_PORT
) (
  input  wire logic                  clk_sys,
  input  wire logic                  srst,
  input  wire dsc_pkg::dsc_apb_req_t apb_req,
  output var  dsc_pkg::dsc_apb_rsp_t apb_rsp,
  input  wire dsc_pkg::dsc_events_t  ev,
  output var  dsc_pkg::dsc_move_t    mv,
  input  wire logic                  mem_ack,
  output      logic                  busy,
  output      logic                  block_done
);
  import dsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  dsc_state_t  state_r;
  logic [3:0]  trig_r;
  logic        dbl_en_r;
  logic [7:0]  frame_r;
  logic [15:0] elem_r;
  logic [15:0] elem_shadow_r;
  logic [7:0]  gfr_r;
  logic        autoinit_r;
  logic [1:0]  src_mode_r;
  logic [1:0]  dst_mode_r;
  logic [15:0] src_r;
  logic [15:0] dst_r;
  logic        pend_r;
  logic        dbl_elem_r;
  dsc_move_t   mv_r;
  logic        done_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;

  logic        sel_ev;
  logic        free_run;
  logic        go;
  logic        elem_done;
  logic        frame_end;
  logic        blk_end;
  logic        hit;
  logic        wr_en;
  logic        wr_sfc;
  logic        wr_elem;
  logic        start;
  logic [31:0] rd_mux;

  function automatic logic [15:0] dsc_step(input logic [15:0] a, input logic [1:0] m, input logic dbl);
    logic [15:0] s;
    s = dbl ? 16'h0002 : 16'h0001;
    if (m == `DSC_MODE_INC) begin
      dsc_step = a + s;
    end else if (m == `DSC_MODE_DEC) begin
      dsc_step = a - s;
    end else begin
      dsc_step = a;
    end
  endfunction : dsc_step

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  always_comb begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    if (apb_req.paddr == `DSC_OFF_SFC) begin
      rd_mux[15:0] = {trig_r, dbl_en_r, 3'b000, frame_r};
    end else if (apb_req.paddr == `DSC_OFF_ELEM) begin
      rd_mux[15:0] = elem_r;
    end else if (apb_req.paddr == `DSC_OFF_GFR) begin
      rd_mux[7:0] = gfr_r;
    end else if (apb_req.paddr == `DSC_OFF_CTRL) begin
      rd_mux[`DSC_CTL_AUTOINIT] = autoinit_r;
      rd_mux[`DSC_CTL_SRC_LSB+:2] = src_mode_r;
      rd_mux[`DSC_CTL_DST_LSB+:2] = dst_mode_r;
    end else if (apb_req.paddr == `DSC_OFF_STAT) begin
      rd_mux[`DSC_ST_BUSY] = busy;
      rd_mux[`DSC_ST_PEND] = pend_r;
      rd_mux[`DSC_ST_SECOND] = (state_r == DSC_SECOND);
    end else if (apb_req.paddr == `DSC_OFF_SRC) begin
      rd_mux[15:0] = src_r;
    end else if (apb_req.paddr == `DSC_OFF_DST) begin
      rd_mux[15:0] = dst_r;
    end else begin
      hit = 1'b0;
    end
  end

  assign wr_en   = apb_req.psel & apb_req.penable & apb_req.pwrite & hit;
  assign wr_sfc  = wr_en & (apb_req.paddr == `DSC_OFF_SFC);
  assign wr_elem = wr_en & (apb_req.paddr == `DSC_OFF_ELEM);
  assign start   = wr_en & (apb_req.paddr == `DSC_OFF_CTRL) & apb_req.pwdata[`DSC_CTL_START]
                   & (state_r == DSC_IDLE);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (apb_req.psel & ~apb_req.penable) begin
      prdata_r  <= apb_req.pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_r <= ~hit;
    end
  end

  assign apb_rsp = '{prdata: prdata_r, pready: 1'b1, pslverr: pslverr_r};

  ////////////////////////////////////////////////////////////////////////////
  // Trigger source selection
  always_comb begin
    sel_ev = 1'b0;
    case (trig_r)
      `DSC_CODE_P0RX: sel_ev = ev.port0_rx_event;
      `DSC_CODE_P0TX: sel_ev = ev.port0_tx_event;
      `DSC_CODE_P1RX: sel_ev = ev.port1_rx_event;
      `DSC_CODE_P1TX: sel_ev = ev.port1_tx_event;
      `DSC_CODE_P2RX: sel_ev = (VARIANT != DSC_VAR_TWO_PORT) & ev.port2_rx_event;
      `DSC_CODE_P2TX: sel_ev = (VARIANT != DSC_VAR_TWO_PORT) & ev.port2_tx_event;
      `DSC_CODE_A0RX: begin
        if (VARIANT == DSC_VAR_THREE_PORT) begin
          sel_ev = ev.port0_alt_rx_event;
        end else if (VARIANT == DSC_VAR_SUBSYS) begin
          sel_ev = ev.fifo_rx_not_empty;
        end
      end
      `DSC_CODE_A0TX: begin
        if (VARIANT == DSC_VAR_THREE_PORT) begin
          sel_ev = ev.port0_alt_tx_event;
        end else if (VARIANT == DSC_VAR_SUBSYS) begin
          sel_ev = ev.fifo_tx_not_full;
        end
      end
      `DSC_CODE_A2RX: sel_ev = (VARIANT == DSC_VAR_THREE_PORT) & ev.port2_alt_rx_event;
      `DSC_CODE_A2TX: sel_ev = (VARIANT == DSC_VAR_THREE_PORT) & ev.port2_alt_tx_event;
      `DSC_CODE_A1RX: sel_ev = (VARIANT == DSC_VAR_THREE_PORT) & ev.port1_alt_rx_event;
      `DSC_CODE_A1TX: sel_ev = (VARIANT == DSC_VAR_THREE_PORT) & ev.port1_alt_tx_event;
      `DSC_CODE_TMR0: sel_ev = (VARIANT != DSC_VAR_SUBSYS) & ev.timer0_event;
      `DSC_CODE_IRQ3: sel_ev = (VARIANT != DSC_VAR_SUBSYS) & ev.ext_irq_three;
      `DSC_CODE_TMR1: sel_ev = (VARIANT == DSC_VAR_TWO_PORT) & ev.timer1_event;
      default:        sel_ev = 1'b0;
    endcase
  end

  assign free_run = (trig_r == `DSC_CODE_NONE);
  assign go       = free_run | pend_r;

  // Pending occurrence; a new event wins over the consume
  always_ff @(posedge clk_sys) begin
    if (srst | start) begin
      pend_r <= 1'b0;
    end else begin
      pend_r <= (pend_r & ~((state_r == DSC_WAIT) & ~free_run)) | (busy & sel_ev);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Element sequencer
  assign elem_done = mem_ack & (((state_r == DSC_FIRST) & ~dbl_elem_r) | (state_r == DSC_SECOND));
  assign frame_end = elem_done & (elem_r == 16'h0000);
  assign blk_end   = frame_end & (frame_r == 8'h00);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_r <= DSC_IDLE;
    end else begin
      case (state_r)
        DSC_IDLE: begin
          if (start) begin
            state_r <= DSC_WAIT;
          end
        end
        DSC_WAIT: begin
          if (go) begin
            state_r <= DSC_FIRST;
          end
        end
        DSC_FIRST: begin
          if (mem_ack & dbl_elem_r) begin
            state_r <= DSC_SECOND;
          end else if (mem_ack) begin
            state_r <= (blk_end & ~autoinit_r) ? DSC_IDLE : DSC_WAIT;
          end
        end
        DSC_SECOND: begin
          if (mem_ack) begin
            state_r <= (blk_end & ~autoinit_r) ? DSC_IDLE : DSC_WAIT;
          end
        end
        default: state_r <= DSC_IDLE;
      endcase
    end
  end

  assign busy = (state_r != DSC_IDLE);

  // Element width latched per element
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dbl_elem_r <= 1'b0;
    end else if ((state_r == DSC_WAIT) & go) begin
      dbl_elem_r <= dbl_en_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mv_r <= '0;
    end else if ((state_r == DSC_WAIT) & go) begin
      mv_r <= '{req: 1'b1, second: 1'b0, src: src_r, dst: dst_r};
    end else if ((state_r == DSC_FIRST) & mem_ack & dbl_elem_r) begin
      mv_r.second <= 1'b1;
      mv_r.src    <= {mv_r.src[15:1], ~mv_r.src[0]};
      mv_r.dst    <= {mv_r.dst[15:1], ~mv_r.dst[0]};
    end else if (elem_done) begin
      mv_r <= '0;
    end
  end

  assign mv = mv_r;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      done_r <= 1'b0;
    end else begin
      done_r <= blk_end;
    end
  end

  assign block_done = done_r;

  ////////////////////////////////////////////////////////////////////////////
  // Sync/frame register and frame counter
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      trig_r   <= `DSC_TRIG_RST;
      dbl_en_r <= 1'b0;
      frame_r  <= `DSC_FRM_RST;
    end else if (wr_sfc) begin
      trig_r   <= apb_req.pwdata[`DSC_TRIG_MSB:`DSC_TRIG_LSB];
      dbl_en_r <= apb_req.pwdata[`DSC_DBL_BIT];
      frame_r  <= apb_req.pwdata[`DSC_FRM_MSB:`DSC_FRM_LSB];
    end else if (frame_end & (frame_r != 8'h00)) begin
      frame_r <= frame_r - 8'h01;
    end else if (blk_end & autoinit_r) begin
      frame_r <= gfr_r;
    end
  end

  // Element counter with shadow reload
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      elem_r        <= `DSC_ELEM_RST;
      elem_shadow_r <= `DSC_ELEM_RST;
    end else if (wr_elem) begin
      elem_r        <= apb_req.pwdata[15:0];
      elem_shadow_r <= apb_req.pwdata[15:0];
    end else if (frame_end) begin
      elem_r <= elem_shadow_r;
    end else if (elem_done) begin
      elem_r <= elem_r - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control, global reload and addresses
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      gfr_r      <= `DSC_FRM_RST;
      autoinit_r <= 1'b0;
      src_mode_r <= `DSC_MODE_HOLD;
      dst_mode_r <= `DSC_MODE_HOLD;
    end else if (wr_en & (apb_req.paddr == `DSC_OFF_GFR)) begin
      gfr_r <= apb_req.pwdata[7:0];
    end else if (wr_en & (apb_req.paddr == `DSC_OFF_CTRL)) begin
      autoinit_r <= apb_req.pwdata[`DSC_CTL_AUTOINIT];
      src_mode_r <= apb_req.pwdata[`DSC_CTL_SRC_LSB+:2];
      dst_mode_r <= apb_req.pwdata[`DSC_CTL_DST_LSB+:2];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      src_r <= `DSC_ADDR_RST;
    end else if (wr_en & (apb_req.paddr == `DSC_OFF_SRC)) begin
      src_r <= apb_req.pwdata[15:0];
    end else if (elem_done) begin
      src_r <= dsc_step(src_r, src_mode_r, dbl_elem_r);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dst_r <= `DSC_ADDR_RST;
    end else if (wr_en & (apb_req.paddr == `DSC_OFF_DST)) begin
      dst_r <= apb_req.pwdata[15:0];
    end else if (elem_done) begin
      dst_r <= dsc_step(dst_r, dst_mode_r, dbl_elem_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence s_first_dbl_done;
    (state_r == DSC_FIRST) && mem_ack && dbl_elem_r;
  endsequence

  sequence s_second_issued;
    (state_r == DSC_SECOND) && mv.req && mv.second;
  endsequence

  a_paced_hold_off: assert property (
    (state_r == DSC_WAIT) && !free_run && !pend_r |=> (state_r == DSC_WAIT) && !mv.req)
    else $error("Paced channel moved without an event");

  a_free_run_now: assert property (
    (state_r == DSC_WAIT) && free_run |=> (state_r == DSC_FIRST) && mv.req)
    else $error("Unpaced channel did not start at once");

  a_event_consumed: assert property (
    (state_r == DSC_WAIT) && !free_run && pend_r && !sel_ev |=> !pend_r)
    else $error("Trigger occurrence not consumed by element");

  a_dword_split: assert property (
    s_first_dbl_done |=> s_second_issued)
    else $error("Double-word element lacks second move");

  a_single_one_move: assert property (
    (state_r == DSC_FIRST) && mem_ack && !dbl_elem_r |=> !mv.req)
    else $error("Single-word element issued a second move");

  a_lsb_flip: assert property (
    s_first_dbl_done |=> mv.src == {$past(mv.src[15:1]), ~$past(mv.src[0])})
    else $error("Second move address not LSB flipped");

  a_frame_decrement: assert property (
    frame_end && (frame_r != 8'h00) && !wr_sfc |=> frame_r == $past(frame_r) - 8'h01)
    else $error("Frame count did not decrement");

  a_autoinit_reload: assert property (
    blk_end && autoinit_r && !wr_sfc |=> (frame_r == $past(gfr_r)) && busy)
    else $error("Autoinit did not reload frame count");

  a_cpu_wins: assert property (
    wr_sfc |=> frame_r == $past(apb_req.pwdata[7:0]))
    else $error("CPU write lost to controller update");

  a_reserved_silent: assert property (
    ((VARIANT == DSC_VAR_SUBSYS) && (trig_r > `DSC_CODE_FIFOTX)) ||
    ((VARIANT == DSC_VAR_TWO_PORT) && (trig_r inside {[`DSC_CODE_P2RX:`DSC_CODE_P2TX], [`DSC_CODE_A0RX:`DSC_CODE_A1TX]}))
    |-> !sel_ev)
    else $error("Reserved trigger code fired");

  a_elem_reload: assert property (
    frame_end && !wr_elem |=> elem_r == elem_shadow_r)
    else $error("Element counter not reloaded at frame end");

  a_reset_values: assert property (
    $past(srst) |-> (trig_r == `DSC_TRIG_RST) && !dbl_en_r && (frame_r == `DSC_FRM_RST))
    else $error("Sync/frame fields not cleared by reset");

endmodule : dsc_channel

`default_nettype wire

//--- dsc_map.svh
// Register offsets, field positions, reset values and trigger codes of the sync/frame channel
`ifndef DSC_MAP_SVH
`define DSC_MAP_SVH

`define DSC_OFF_SFC      8'h00
`define DSC_OFF_ELEM     8'h04
`define DSC_OFF_GFR      8'h08
`define DSC_OFF_CTRL     8'h0C
`define DSC_OFF_STAT     8'h10
`define DSC_OFF_SRC      8'h14
`define DSC_OFF_DST      8'h18

`define DSC_TRIG_MSB     15
`define DSC_TRIG_LSB     12
`define DSC_DBL_BIT      11
`define DSC_FRM_MSB      7
`define DSC_FRM_LSB      0

`define DSC_TRIG_RST     4'h0
`define DSC_FRM_RST      8'h00
`define DSC_ELEM_RST     16'h0000
`define DSC_ADDR_RST     16'h0000

`define DSC_CTL_START    0
`define DSC_CTL_AUTOINIT 1
`define DSC_CTL_SRC_LSB  4
`define DSC_CTL_DST_LSB  6

`define DSC_ST_BUSY      0
`define DSC_ST_PEND      1
`define DSC_ST_SECOND    2

`define DSC_MODE_HOLD    2'h0
`define DSC_MODE_INC     2'h1
`define DSC_MODE_DEC     2'h2

`define DSC_CODE_NONE    4'h0
`define DSC_CODE_P0RX    4'h1
`define DSC_CODE_P0TX    4'h2
`define DSC_CODE_P2RX    4'h3
`define DSC_CODE_P2TX    4'h4
`define DSC_CODE_P1RX    4'h5
`define DSC_CODE_P1TX    4'h6
`define DSC_CODE_A0RX    4'h7
`define DSC_CODE_A0TX    4'h8
`define DSC_CODE_FIFORX  4'h7
`define DSC_CODE_FIFOTX  4'h8
`define DSC_CODE_A2RX    4'h9
`define DSC_CODE_A2TX    4'hA
`define DSC_CODE_A1RX    4'hB
`define DSC_CODE_A1TX    4'hC
`define DSC_CODE_TMR0    4'hD
`define DSC_CODE_IRQ3    4'hE
`define DSC_CODE_TMR1    4'hF

`endif

//--- dsc_mem_model.sv
// Memory model completing channel moves after a programmable delay
`timescale 1ns/10ps
`default_nettype none

module dsc_mem_model (
  input  wire logic               clk_sys,
  input  wire logic               srst,
  input  wire dsc_pkg::dsc_move_t mv,
  input  wire logic [3:0]         delay,
  output var  logic               mem_ack,
  output var  logic [15:0]        n_moves,
  output var  dsc_pkg::dsc_move_t last_mv
);
  import dsc_pkg::*;
  logic [3:0] wait_r;

  ////////////////////////////////////////////////////////////////
  // Ack pulse, never while the previous ack is still high
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mem_ack <= 1'b0;
      wait_r  <= 4'h0;
    end else if (mv.req && !mem_ack) begin
      mem_ack <= (wait_r >= delay);
      wait_r  <= (wait_r >= delay) ? 4'h0 : wait_r + 4'h1;
    end else begin
      mem_ack <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Log of completed moves
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      n_moves <= 16'h0000;
      last_mv <= '0;
    end else if (mem_ack && mv.req) begin
      n_moves <= n_moves + 16'h0001;
      last_mv <= mv;
    end
  end
endmodule : dsc_mem_model

`default_nettype wire

//--- dsc_pkg.sv
// Types shared by the sync/frame channel and its bench
`default_nettype none
package dsc_pkg;

  typedef enum logic [3:0] {
    DSC_IDLE   = 4'b0001,
    DSC_WAIT   = 4'b0010,
    DSC_FIRST  = 4'b0100,
    DSC_SECOND = 4'b1000
  } dsc_state_t;

  typedef enum logic [1:0] {
    DSC_VAR_TWO_PORT   = 2'b00,
    DSC_VAR_THREE_PORT = 2'b01,
    DSC_VAR_SUBSYS     = 2'b10
  } dsc_variant_t;

  typedef struct packed {
    logic port0_rx_event;
    logic port0_tx_event;
    logic port1_rx_event;
    logic port1_tx_event;
    logic port2_rx_event;
    logic port2_tx_event;
    logic port0_alt_rx_event;
    logic port0_alt_tx_event;
    logic port2_alt_rx_event;
    logic port2_alt_tx_event;
    logic port1_alt_rx_event;
    logic port1_alt_tx_event;
    logic timer0_event;
    logic timer1_event;
    logic ext_irq_three;
    logic fifo_rx_not_empty;
    logic fifo_tx_not_full;
  } dsc_events_t;

  typedef struct packed {
    logic        req;
    logic        second;
    logic [15:0] src;
    logic [15:0] dst;
  } dsc_move_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } dsc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } dsc_apb_rsp_t;

endpackage : dsc_pkg

`default_nettype wire

//--- test_dma_channel_sync_frame_control.sv
// Self-checking bench for the sync/frame DMA channel
`timescale 1ns/10ps
`default_nettype none
`include "dsc_map.svh"

module test_dma_channel_sync_frame_control;
  import dsc_pkg::*;
  logic         clk_sys    = 1'b0;
  logic         srst       = 1'b1;
  dsc_apb_req_t apb_req    = '0;
  dsc_apb_rsp_t apb_rsp;
  dsc_events_t  ev         = '0;
  dsc_move_t    mv;
  dsc_move_t    last_mv;
  logic         mem_ack;
  logic         busy;
  logic         block_done;
  logic [3:0]   delay      = 4'h0;
  logic [15:0]  n_moves;
  int           mismatches = 0;
  int           n_compared = 0;

  always #25 clk_sys = ~clk_sys;

  dsc_channel #(.VARIANT(DSC_VAR_TWO_PORT)) u_dut (
    .clk_sys(clk_sys), .srst(srst), .apb_req(apb_req), .apb_rsp(apb_rsp), .ev(ev),
    .mv(mv), .mem_ack(mem_ack), .busy(busy), .block_done(block_done));

  dsc_mem_model u_mem (
    .clk_sys(clk_sys), .srst(srst), .mv(mv), .delay(delay), .mem_ack(mem_ack),
    .n_moves(n_moves), .last_mv(last_mv));

  ////////////////////////////////////////////////////////////////
  // Shared tasks
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk_sys);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (apb_rsp.pready !== 1'b1);
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req <= '0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
  endtask : rd

  task pulse(input logic [16:0] p);
    @(posedge clk_sys);
    ev <= p;
    @(posedge clk_sys);
    ev <= '0;
  endtask : pulse

  task idle(input int k);
    repeat (k) @(negedge clk_sys);
  endtask : idle

  task wait_done(output int n);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (block_done !== 1'b1 && n < 2000);
    if (n >= 2000) chk("block_done", {31'h0, block_done}, 32'h0000_0001);
  endtask : wait_done

  // Event bit in the packed event struct per trigger code, -1 when reserved
  function automatic int ev_bit(input int c);
    case (c)
      1: return 16;
      2: return 15;
      5: return 14;
      6: return 13;
      13: return 4;
      14: return 2;
      15: return 3;
      default: return -1;
    endcase
  endfunction : ev_bit

  ////////////////////////////////////////////////////////////////
  // Scenarios
  task t_reset;
    logic [31:0] q;
    logic        e;
    for (int i = 0; i < 7; i++) begin
      rd(8'(i * 4), q);
      chk("reset value", q, 32'h0000_0000);
    end
    wr(`DSC_OFF_SFC, 32'hFFFF_FFFF);
    rd(`DSC_OFF_SFC, q);
    chk("sfc fields", q, 32'h0000_F8FF);
    apb(1'b0, 8'h40, 32'h0000_0000, q, e);
    chk("unmapped err", {31'h0, e}, 32'h0000_0001);
  endtask : t_reset

  task t_codes;
    logic [16:0] p;
    logic [15:0] n0;
    int          b;
    int          t;
    for (int c = 1; c < 16; c++) begin
      b  = ev_bit(c);
      n0 = n_moves;
      wr(`DSC_OFF_SFC, {16'h0000, c[3:0], 12'h000});
      wr(`DSC_OFF_ELEM, 32'h0000_0000);
      wr(`DSC_OFF_CTRL, 32'h0000_0001);
      p = '1;
      if (b >= 0) p[b] = 1'b0;
      pulse(p);
      idle(8);
      chk("held moves", {16'h0, n_moves}, {16'h0, n0});
      if (b >= 0) pulse(17'h0_0001 << b);
      else wr(`DSC_OFF_SFC, 32'h0000_0000);
      wait_done(t);
      chk("paced moves", {16'h0, n_moves}, {16'h0, n0 + 16'h0001});
    end
  endtask : t_codes

  task t_double;
    logic [31:0] q;
    logic [15:0] n0;
    int          t;
    delay = 4'h4;
    n0    = n_moves;
    wr(`DSC_OFF_SFC, 32'h0000_D800);
    wr(`DSC_OFF_ELEM, 32'h0000_0000);
    wr(`DSC_OFF_SRC, 32'h0000_0011);
    wr(`DSC_OFF_DST, 32'h0000_0020);
    wr(`DSC_OFF_CTRL, 32'h0000_0091);
    pulse(17'h0_0010);
    wait_done(t);
    chk("double moves", {16'h0, n_moves}, {16'h0, n0 + 16'h0002});
    chk("second flag", {31'h0, last_mv.second}, 32'h0000_0001);
    chk("second src", {16'h0, last_mv.src}, 32'h0000_0010);
    chk("second dst", {16'h0, last_mv.dst}, 32'h0000_0021);
    rd(`DSC_OFF_SRC, q);
    chk("src step", q, 32'h0000_0013);
    rd(`DSC_OFF_DST, q);
    chk("dst step", q, 32'h0000_001E);
    delay = 4'h0;
  endtask : t_double

  task t_autoinit;
    logic [31:0] q;
    int          t;
    wr(`DSC_OFF_GFR, 32'h0000_0001);
    wr(`DSC_OFF_SFC, 32'h0000_1000);
    wr(`DSC_OFF_ELEM, 32'h0000_0000);
    wr(`DSC_OFF_CTRL, 32'h0000_0003);
    pulse(17'h1_0000);
    idle(8);
    chk("busy after reload", {31'h0, busy}, 32'h0000_0001);
    rd(`DSC_OFF_SFC, q);
    chk("frame reload", q, 32'h0000_1001);
    pulse(17'h1_0000);
    idle(8);
    rd(`DSC_OFF_SFC, q);
    chk("frame decrement", q, 32'h0000_1000);
    // Write lands on the same edge as the block-end reload
    pulse(17'h1_0000);
    wr(`DSC_OFF_SFC, 32'h0000_1005);
    rd(`DSC_OFF_SFC, q);
    chk("cpu wins", q, 32'h0000_1005);
    wr(`DSC_OFF_CTRL, 32'h0000_0000);
    wr(`DSC_OFF_SFC, 32'h0000_0000);
    wait_done(t);
  endtask : t_autoinit

  task t_unpaced;
    logic [31:0] q;
    logic [15:0] n0;
    int          t;
    n0 = n_moves;
    wr(`DSC_OFF_SFC, 32'h0000_0002);
    wr(`DSC_OFF_ELEM, 32'h0000_0001);
    wr(`DSC_OFF_SRC, 32'h0000_0100);
    wr(`DSC_OFF_DST, 32'h0000_0200);
    wr(`DSC_OFF_CTRL, 32'h0000_0051);
    wait_done(t);
    chk("fast run", {31'h0, t <= 40}, 32'h0000_0001);
    chk("idle after block", {31'h0, busy}, 32'h0000_0000);
    chk("block moves", {16'h0, n_moves}, {16'h0, n0 + 16'h0006});
    chk("last src", {16'h0, last_mv.src}, 32'h0000_0105);
    chk("last dst", {16'h0, last_mv.dst}, 32'h0000_0205);
    rd(`DSC_OFF_SFC, q);
    chk("frames spent", q, 32'h0000_0000);
    rd(`DSC_OFF_ELEM, q);
    chk("elem shadow", q, 32'h0000_0001);
  endtask : t_unpaced

  ////////////////////////////////////////////////////////////////
  // Verdict and main sequence
  task end_of_test;
    if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test

  initial begin
    #1_000_000;
    mismatches++;
    end_of_test();
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    t_reset();
    t_codes();
    t_double();
    t_autoinit();
    t_unpaced();
    end_of_test();
  end
endmodule : test_dma_channel_sync_frame_control

`default_nettype wire
